//--- inc/wdt_pkg.sv
// Constants for the 16-bit watchdog timer: register map, control fields,
// reset values and prescaler terminal counts.
// Assumes a 32-bit APB register bus and a 100 MHz pclk.
package wdt_pkg;
    // ==========================================================
    // Register byte addresses
    // ==========================================================
    localparam logic [31:0] ADDR_RELOAD  = 32'hFFFF_0360;
    localparam logic [31:0] ADDR_COUNT   = 32'hFFFF_0364;
    localparam logic [31:0] ADDR_CONTROL = 32'h0FFF_0368;
    localparam logic [31:0] ADDR_REFRESH = 32'hFFFF_036C;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [15:0] RST_RELOAD  = 16'h0040;
    localparam logic [15:0] RST_COUNT   = 16'h0040;
    localparam logic [15:0] RST_CONTROL = 16'h0000;

    // ==========================================================
    // Control field positions
    // ==========================================================
    localparam int CTL_UP      = 8;
    localparam int CTL_ENABLE  = 7;
    localparam int CTL_PERIOD  = 6;
    localparam int CTL_WDOG    = 5;
    localparam int CTL_PRE_HI  = 3;
    localparam int CTL_PRE_LO  = 2;
    localparam int CTL_IRQ_EN  = 1;
    localparam int CTL_PD_STOP = 0;
    // Bits that hold state; reserved bits 15:9 and 4 read as zero.
    localparam logic [15:0] CTL_MASK = 16'h01EF;

    // ==========================================================
    // Prescaler selections and terminal counts
    // ==========================================================
    localparam logic [1:0] PRE_DIV1   = 2'h0;
    localparam logic [1:0] PRE_DIV16  = 2'h1;
    localparam logic [1:0] PRE_DIV256 = 2'h2;
    localparam logic [7:0] TERM_DIV1   = 8'h00;
    localparam logic [7:0] TERM_DIV16  = 8'h0F;
    localparam logic [7:0] TERM_DIV256 = 8'hFF;

    // ==========================================================
    // Counter limits and nominal timing
    // ==========================================================
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_FULL = 16'hFFFF;
    localparam int OSC_HZ        = 32768;
    localparam int MAX_TIMEOUT_S = 512;
endpackage : wdt_pkg

//--- logic/wdt_timer.sv
// 16-bit timer with watchdog mode, reached over APB.
// Assumes presetn is the power-on reset only, and that the slow
// oscillator, debug halt and power-down levels arrive asynchronously.
//
// Function
// - Control bit 5 enters watchdog operation.
// - Watchdog counts down from reload to zero.
// - Full reload at /256 gives 512 s.
// - At zero: interrupt if bit 1, else reset.
// - Refresh write reloads counter, restarts timeout.
// - Watchdog locks reload and control registers.
// - Only power-on reset clears the timer.
// - Counter stops while debugger holds core.
// - Bit 0 stops counting during power-down.
// - Slow oscillator through /1, /16, /256.
// - Overflow reloads counter from reload register.
// - Normal mode refresh write clears interrupt.
// - Control bit 8 selects count direction.
// - Control bit 7 enables the counter.
// - Bit 6 periodic reload, else free run.
// - Reload and count are 16-bit; count read-only.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module wdt_timer
    import wdt_pkg::*;
(
    // APB clock and power-on reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Asynchronous inputs
    input  wire logic        lp_osc_clk,
    input  wire logic        debug_halt,
    input  wire logic        periph_powerdown,
    // Timer events
    output logic             wdt_irq,
    output logic             wdt_reset_req
);
    // ==========================================================
    // Synchronisers
    // ==========================================================
    // Three stages each; an edge counts while stage two is high and stage three is still low.
    logic [2:0] osc_s_q;
    logic [2:0] halt_s_q;
    logic [2:0] pd_s_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            osc_s_q  <= 3'h0;
            halt_s_q <= 3'h0;
            pd_s_q   <= 3'h0;
        end
        else
        begin
            osc_s_q  <= {osc_s_q[1:0], lp_osc_clk};
            halt_s_q <= {halt_s_q[1:0], debug_halt};
            pd_s_q   <= {pd_s_q[1:0], periph_powerdown};
        end
    end

    wire osc_edge = osc_s_q[1] & ~osc_s_q[2];
    wire halted   = halt_s_q[2];
    wire pd_level = pd_s_q[2];

    // ==========================================================
    // Registers
    // ==========================================================
    // Only presetn clears these; other system resets never reach them.
    logic [15:0] reload_q;
    logic [15:0] cnt_q;
    logic [15:0] ctrl_q;
    logic [7:0]  ps_q;
    logic        step_q;
    logic        irq_q;
    logic        rst_req_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    wire up_mode   = ctrl_q[CTL_UP];
    wire enabled   = ctrl_q[CTL_ENABLE];
    wire periodic  = ctrl_q[CTL_PERIOD];
    wire wd_mode   = ctrl_q[CTL_WDOG];
    wire irq_en    = ctrl_q[CTL_IRQ_EN];
    wire pd_stop   = ctrl_q[CTL_PD_STOP];
    wire [1:0] pre = ctrl_q[CTL_PRE_HI:CTL_PRE_LO];

    // ==========================================================
    // APB decode
    // ==========================================================
    // One wait state: pready rises in the second access cycle, so that
    // read data and the error flag can come straight from flip-flops.
    wire acc       = psel & penable;
    wire fire      = acc & pready_q;
    wire hit_rel   = (paddr == ADDR_RELOAD);
    wire hit_cnt   = (paddr == ADDR_COUNT);
    wire hit_ctl   = (paddr == ADDR_CONTROL);
    wire hit_ref   = (paddr == ADDR_REFRESH);
    wire mapped    = hit_rel | hit_cnt | hit_ctl | hit_ref;
    wire wr        = fire & pwrite;
    wire wr_rel    = wr & hit_rel & ~wd_mode;
    wire wr_ctl    = wr & hit_ctl & ~wd_mode;
    wire wr_ref    = wr & hit_ref;
    wire wd_entry  = wr_ctl & pwdata[CTL_WDOG];

    // The count register is read-only and refresh reads as zero.
    wire [31:0] rd_mux = hit_rel ? {16'h0000, reload_q} :
                         hit_cnt ? {16'h0000, cnt_q} :
                         hit_ctl ? {16'h0000, ctrl_q} :
                         32'h0000_0000;

    wire pready_d  = acc & ~pready_q;
    wire [31:0] prdata_d  = (pready_d & ~pwrite) ? rd_mux : 32'h0000_0000;
    wire pslverr_d = pready_d & ~mapped;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ==========================================================
    // Configuration
    // ==========================================================
    // Reserved control bits are dropped on write, so they read as zero.
    wire [15:0] ctrl_d   = wr_ctl ? (pwdata[15:0] & CTL_MASK) : ctrl_q;
    wire [15:0] reload_d = wr_rel ? pwdata[15:0] : reload_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q   <= RST_CONTROL;
            reload_q <= RST_RELOAD;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            reload_q <= reload_d;
        end
    end

    // ==========================================================
    // Prescaler
    // ==========================================================
    // The reserved prescale code behaves as /256.
    wire [7:0] term = (pre == PRE_DIV1)  ? TERM_DIV1 :
                      (pre == PRE_DIV16) ? TERM_DIV16 :
                      TERM_DIV256;

    // Watchdog mode runs even with the enable bit clear, since the
    // control register can no longer be changed once it is entered.
    wire run = (enabled | wd_mode)
               & ~halted
               & ~(pd_level & pd_stop);

    wire       ps_wrap = osc_edge & run & (ps_q >= term);
    wire [7:0] ps_d    = ps_wrap ? 8'h00 :
                         (osc_edge & run) ? ps_q + 8'h01 : ps_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ps_q   <= 8'h00;
            step_q <= 1'b0;
        end
        else
        begin
            ps_q   <= ps_d;
            step_q <= ps_wrap;
        end
    end

    // ==========================================================
    // Counter
    // ==========================================================
    // Full reload at /256 gives 65536 * 256 / 32768 = 512 s.
    wire at_zero = (cnt_q == CNT_ZERO);
    wire at_full = (cnt_q == CNT_FULL);
    wire wd_evt  = step_q & wd_mode & at_zero;
    wire dn_evt  = step_q & ~wd_mode & ~up_mode & at_zero;
    wire up_evt  = step_q & ~wd_mode & up_mode & at_full;
    wire evt     = wd_evt | dn_evt | up_evt;

    wire [15:0] cnt_stepped =
        (up_mode & ~wd_mode) ? cnt_q + 16'h0001 :
                               cnt_q - 16'h0001;

    wire [15:0] cnt_d =
        wd_entry               ? reload_q :
        (wr_ref & wd_mode)     ? reload_q :
        wd_evt                 ? reload_q :
        ((dn_evt | up_evt) & periodic) ? reload_q :
        step_q                 ? cnt_stepped :
        cnt_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= RST_COUNT;
        else
            cnt_q <= cnt_d;
    end

    // ==========================================================
    // Events
    // ==========================================================
    // A new event in the cycle of a refresh write keeps the flag set.
    wire irq_set = wd_evt ? irq_en : evt;
    wire irq_d   = irq_set | (irq_q & ~wr_ref);
    wire rst_d   = wd_evt & ~irq_en;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q     <= 1'b0;
            rst_req_q <= 1'b0;
        end
        else
        begin
            irq_q     <= irq_d;
            rst_req_q <= rst_d;
        end
    end

    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign wdt_irq       = irq_q;
    assign wdt_reset_req = rst_req_q;

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    wd_entry_a: assert property (wd_entry |=> wd_mode && cnt_q == $past(reload_q))
        else $error("watchdog entry did not load counter");

    wd_decrement_a: assert property (
        step_q && wd_mode && !at_zero && !wr_ref |=> cnt_q == $past(cnt_q) - 16'h0001)
        else $error("watchdog did not decrement");

    wd_reset_out_a: assert property (
        wd_evt && !irq_en |=> rst_req_q && !$rose(irq_q) ##1 !rst_req_q)
        else $error("watchdog reset pulse wrong");

    wd_irq_out_a: assert property (wd_evt && irq_en |=> irq_q && !rst_req_q)
        else $error("watchdog interrupt missing");

    refresh_reload_a: assert property (wr_ref && wd_mode |=> cnt_q == reload_q)
        else $error("refresh did not reload counter");

    config_lock_a: assert property (
        wd_mode && wr && (hit_ctl || hit_rel) |=> $stable(ctrl_q) && $stable(reload_q))
        else $error("locked register changed");

    debug_halt_a: assert property (halted |=> !step_q)
        else $error("counter stepped during debug halt");

    pd_stop_a: assert property (pd_level && pd_stop |=> !step_q)
        else $error("counter stepped in power-down");

    prescale_a: assert property (step_q |-> ps_q == 8'h00)
        else $error("prescaler step misaligned");

    periodic_reload_a: assert property (
        up_evt && periodic && !wd_entry |=> cnt_q == $past(reload_q) && irq_q)
        else $error("overflow did not reload");

    irq_clear_a: assert property (
        irq_q && wr_ref && !evt |=> !irq_q)
        else $error("refresh did not clear interrupt");

    count_up_a: assert property (
        step_q && !wd_mode && up_mode && !at_full && !wd_entry
        |=> cnt_q == $past(cnt_q) + 16'h0001)
        else $error("count up wrong");

    disabled_a: assert property (!enabled && !wd_mode |=> !step_q)
        else $error("disabled counter stepped");

    free_wrap_a: assert property (
        dn_evt && !periodic && !wd_entry |=> cnt_q == CNT_FULL)
        else $error("free-running wrap wrong");

    irq_hold_a: assert property (irq_q && !wr_ref |=> irq_q)
        else $error("interrupt dropped early");

    pready_pulse_a: assert property (pready_q |=> !pready_q)
        else $error("ready held longer than one cycle");

    pready_wait_a: assert property (acc && !pready_q |=> pready_q)
        else $error("ready missing after one wait state");

    rdata_idle_a: assert property (!pready_q |-> prdata_q == 32'h0000_0000)
        else $error("read data not zero outside ready");

    slverr_map_a: assert property (pready_q |-> pslverr_q == !$past(mapped))
        else $error("error response does not match decode");

    count_ro_a: assert property (wr && hit_cnt && !step_q |=> $stable(cnt_q))
        else $error("count register changed by a write");

    wd_sticky_a: assert property (wd_mode |=> wd_mode)
        else $error("watchdog mode left without power-on reset");

    reset_pulse_a: assert property (rst_req_q |=> !rst_req_q)
        else $error("reset request longer than one cycle");

    no_reset_normal_a: assert property (!wd_mode |=> !rst_req_q)
        else $error("reset request outside watchdog mode");

    refresh_normal_a: assert property (wr_ref && !wd_mode && !step_q |=> $stable(cnt_q))
        else $error("normal mode refresh changed the count");

    div1_step_a: assert property (osc_edge && run && pre == PRE_DIV1 |=> step_q)
        else $error("undivided oscillator edge gave no step");

    up_free_wrap_a: assert property (up_evt && !periodic && !wd_entry |=> cnt_q == CNT_ZERO)
        else $error("free-running up wrap wrong");

    down_periodic_a: assert property (
        dn_evt && periodic && !wd_entry |=> cnt_q == $past(reload_q) && irq_q)
        else $error("down count did not reload");

    halt_freeze_a: assert property (halted && !wr_ref && !wd_entry |=> $stable(cnt_q))
        else $error("count moved during debug halt");

    irq_clear_c: cover property (irq_q && wr_ref);
    wd_reset_c: cover property (wd_evt && !irq_en);
    wd_refresh_c: cover property (wd_mode && wr_ref ##[1:200] step_q);
    up_wrap_c: cover property (up_evt && periodic);
    err_resp_c: cover property (pslverr_q && pready_q);
endmodule : wdt_timer

//--- verif/watchdog_timer_16bit_tb.sv
// Self-checking testbench for the watchdog timer: APB register tasks drive
// the block, and the bench toggles the slow oscillator, debug and power pins.
// Waits up to 50 cycles for each APB answer rather than assuming one wait state.
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
    $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module watchdog_timer_16bit_tb
    import wdt_pkg::*;
;
    // Clock, reset and APB
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [31:0] paddr   = 32'h0000_0000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    // Timer pins
    logic        lp_osc_clk       = 1'b0;
    logic        debug_halt       = 1'b0;
    logic        periph_powerdown = 1'b0;
    logic        wdt_irq;
    logic        wdt_reset_req;
    // Bench state
    int          err_total   = 0;
    int          comparisons = 0;
    int          rst_seen    = 0;
    logic        last_err;
    logic [31:0] rdat;

    always #5 pclk = ~pclk;

    wdt_timer u_wdt_timer (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .lp_osc_clk(lp_osc_clk),
        .debug_halt(debug_halt), .periph_powerdown(periph_powerdown),
        .wdt_irq(wdt_irq), .wdt_reset_req(wdt_reset_req)
    );

    always @(posedge pclk)
    begin
        if (wdt_reset_req === 1'b1)
            rst_seen++;
    end

    // ==========================================================
    // Access tasks
    // ==========================================================
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // The answer is awaited with a bound rather than assumed.
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
            err_total++;
        d        = prdata;
        last_err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] wd);
        logic [31:0] d;
        apb(1'b1, a, wd, d);
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] d;
        apb(1'b0, a, 32'h0000_0000, d);
        `CHK(d, exp)
    endtask : rd_chk

    // One slow oscillator period; edges stay well over four pclk apart.
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            lp_osc_clk <= 1'b1;
            repeat (8) @(posedge pclk);
            lp_osc_clk <= 1'b0;
            repeat (8) @(posedge pclk);
        end
    endtask : tick

    task automatic por();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
    endtask : por

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : results

    initial
    begin
        repeat (30000) @(posedge pclk);
        err_total++;
        results();
    end

    // ==========================================================
    // Tests
    // ==========================================================
    initial
    begin
        por();
        rd_chk(ADDR_RELOAD, {16'h0000, RST_RELOAD});
        rd_chk(ADDR_COUNT, {16'h0000, RST_COUNT});
        rd_chk(ADDR_CONTROL, {16'h0000, RST_CONTROL});
        rd_chk(32'hFFFF_0370, 32'h0000_0000);
        `CHK(last_err, 1'b1)
        rd_chk(ADDR_REFRESH, 32'h0000_0000);
        `CHK(last_err, 1'b0)
        wr(ADDR_CONTROL, 32'h0000_FE10);
        rd_chk(ADDR_CONTROL, 32'h0000_0000);
        wr(ADDR_COUNT, 32'h0000_1111);
        rd_chk(ADDR_COUNT, 32'h0000_0040);
        tick(1);
        rd_chk(ADDR_COUNT, 32'h0000_0040);
        wr(ADDR_CONTROL, 32'h0000_0080);
        tick(1);
        rd_chk(ADDR_COUNT, 32'h0000_003F);
        debug_halt <= 1'b1;
        repeat (8) @(posedge pclk);
        tick(1);
        rd_chk(ADDR_COUNT, 32'h0000_003F);
        debug_halt       <= 1'b0;
        periph_powerdown <= 1'b1;
        wr(ADDR_CONTROL, 32'h0000_0081);
        tick(1);
        rd_chk(ADDR_COUNT, 32'h0000_003F);
        wr(ADDR_CONTROL, 32'h0000_0080);
        tick(1);
        rd_chk(ADDR_COUNT, 32'h0000_003E);
        periph_powerdown <= 1'b0;
        repeat (8) @(posedge pclk);
        tick(62);
        rd_chk(ADDR_COUNT, 32'h0000_0000);
        `CHK(wdt_irq, 1'b0)
        // Free-running down count wraps to full scale, not to the reload value.
        tick(1);
        rd_chk(ADDR_COUNT, {16'h0000, CNT_FULL});
        repeat (20) @(posedge pclk);
        `CHK(wdt_irq, 1'b1)
        wr(ADDR_REFRESH, 32'h0000_00A5);
        @(posedge pclk);
        `CHK(wdt_irq, 1'b0)
        rd_chk(ADDR_COUNT, {16'h0000, CNT_FULL});
        wr(ADDR_RELOAD, 32'h0000_1234);
        rd_chk(ADDR_RELOAD, 32'h0000_1234);
        wr(ADDR_CONTROL, 32'h0000_01C0);
        tick(1);
        rd_chk(ADDR_COUNT, 32'h0000_1234);
        `CHK(wdt_irq, 1'b1)
        wr(ADDR_REFRESH, 32'h0000_0000);
        wr(ADDR_CONTROL, 32'h0000_0184);
        tick(16);
        rd_chk(ADDR_COUNT, 32'h0000_1235);
        wr(ADDR_CONTROL, 32'h0000_0188);
        tick(256);
        rd_chk(ADDR_COUNT, 32'h0000_1236);
        // Watchdog with interrupt option.
        wr(ADDR_RELOAD, 32'h0000_0003);
        wr(ADDR_CONTROL, 32'h0000_0022);
        rd_chk(ADDR_COUNT, 32'h0000_0003);
        tick(3);
        rd_chk(ADDR_COUNT, 32'h0000_0000);
        tick(1);
        `CHK(wdt_irq, 1'b1)
        rd_chk(ADDR_COUNT, 32'h0000_0003);
        tick(1);
        wr(ADDR_REFRESH, 32'h0000_0011);
        @(posedge pclk);
        `CHK(wdt_irq, 1'b0)
        rd_chk(ADDR_COUNT, 32'h0000_0003);
        wr(ADDR_RELOAD, 32'h0000_0055);
        rd_chk(ADDR_RELOAD, 32'h0000_0003);
        wr(ADDR_CONTROL, 32'h0000_0000);
        rd_chk(ADDR_CONTROL, 32'h0000_0022);
        `CHK(rst_seen, 0)
        // Only power-on reset unlocks; then the reset option is exercised.
        por();
        rd_chk(ADDR_CONTROL, 32'h0000_0000);
        rd_chk(ADDR_RELOAD, 32'h0000_0040);
        wr(ADDR_RELOAD, 32'h0000_0002);
        wr(ADDR_CONTROL, 32'h0000_0020);
        tick(2);
        `CHK(rst_seen, 0)
        tick(1);
        `CHK(rst_seen, 1)
        `CHK(wdt_irq, 1'b0)
        results();
    end
endmodule : watchdog_timer_16bit_tb
